/* File: include/pefcfg_pkg.sv */
// Purpose: Shared constants of the equalizer filter configuration block
// Assumes: Wishbone word index = byte address / 4
// Notes: Indices marked for the second channel and link are local choices
`default_nettype none
package pefcfg_pkg;
    // Data widths
    localparam int SAMPLE_W = 12;
    localparam int COEF_W = 12;
    localparam int CENTER_W = 18;
    localparam int ACC_W = 36;
    localparam int IDX_W = 14;
    // Register word indices
    localparam logic [IDX_W-1:0] IDX_CFG = 14'h0400;
    localparam logic [IDX_W-1:0] IDX_TAP0 = 14'h0418;
    localparam logic [IDX_W-1:0] IDX_TAP1 = 14'h041A;
    localparam logic [IDX_W-1:0] IDX_CENTER = 14'h0420;
    localparam logic [IDX_W-1:0] IDX_B_TAP0 = 14'h0440;
    localparam logic [IDX_W-1:0] IDX_B_TAP1 = 14'h0442;
    localparam logic [IDX_W-1:0] IDX_B_CENTER = 14'h0448;
    localparam logic [IDX_W-1:0] IDX_LINK = 14'h0460;
    localparam logic [IDX_W-1:0] IDX_STATUS = 14'h0461;
    // Register widths
    localparam int CFG_W = 8;
    localparam int TAP_W = 16;
    localparam int CREG_W = 24;
    // Configuration field positions
    localparam int CFG_MODE_LSB = 0;
    localparam int CFG_SCW_LSB = 2;
    localparam int CFG_MERGE_BIT = 5;
    localparam int CFG_SHARE_BIT = 6;
    // Status bit positions
    localparam int STAT_ACTIVE_BIT = 0;
    localparam int STAT_RSVD_BIT = 1;
    localparam int STAT_LATE_BIT = 2;
    // Field encodings
    localparam logic [1:0] MODE_OFF = 2'h0;
    localparam logic [1:0] MODE_ON = 2'h2;
    localparam logic [2:0] SCW_MAX = 3'h6;
    localparam int WEIGHT_FRAC = 16;
    // Reset values
    localparam logic [CFG_W-1:0] CFG_RST = 8'h00;
    localparam logic [TAP_W-1:0] TAP_RST = 16'h0000;
    localparam logic [CREG_W-1:0] CREG_RST = 24'h000000;
    localparam logic LINK_RST = 1'b0;
endpackage : pefcfg_pkg
`default_nettype wire

/* File: rtl/pefcfg_buf.sv */
// Purpose: Small FIFO between the filter and the sample consumer
// Assumes: DEPTH is a power of two
// Notes: in_ready_o low when full, out_valid_o low when empty
`default_nettype none
module pefcfg_buf #(
    parameter int W = 24,
    parameter int DEPTH = 2
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [W-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [W-1:0] out_data_o
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL = CW'(DEPTH);

    logic [W-1:0] mem_q [DEPTH];
    logic [PW-1:0] wr_q;
    logic [PW-1:0] rd_q;
    logic [CW-1:0] cnt_q;
    logic push;
    logic pop;

    // Handshake terms
    assign in_ready_o = (cnt_q != FULL);
    assign out_valid_o = (cnt_q != '0);
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;
    assign out_data_o = mem_q[rd_q];

    // Storage
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_q[wr_q] <= in_data_i;
        end
    end

    // Pointers and fill level
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= PW'(wr_q + 1'b1);
            end
            if (pop) begin
                rd_q <= PW'(rd_q + 1'b1);
            end
            if (push && !pop) begin
                cnt_q <= CW'(cnt_q + 1'b1);
            end else if (pop && !push) begin
                cnt_q <= CW'(cnt_q - 1'b1);
            end
        end
    end
endmodule : pefcfg_buf
`default_nettype wire

/* File: rtl/pefcfg_top.sv */
// Purpose: Equalizer filter configuration, coefficient store, datapath
// Assumes: One sample pair per accepted beat, channel a first
// Notes: Only taps 0, 1 and the center tap are held here
`default_nettype none
module pefcfg_top
    import pefcfg_pkg::*;
#(
    parameter int ADR_W = 16,
    parameter int BUF_DEPTH = 2
) (
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone classic slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [ADR_W-1:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Sample input stream
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [SAMPLE_W-1:0] in_a_i,
    input wire logic [SAMPLE_W-1:0] in_b_i,
    // Sample output stream
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [SAMPLE_W-1:0] out_a_o,
    output logic [SAMPLE_W-1:0] out_b_o,
    // Link enable as held in the control register
    output logic serial_link_enable_o
);
    typedef logic signed [ACC_W-1:0] pefcfg_acc_t;

    // Side tap product scaled by the side weight
    function automatic pefcfg_acc_t side_term(
        input logic [TAP_W-1:0] r,
        input logic [SAMPLE_W-1:0] s,
        input logic [2:0] scw
    );
        logic signed [COEF_W-1:0] c;
        logic signed [SAMPLE_W-1:0] x;
        pefcfg_acc_t p;
        c = r[COEF_W-1:0];
        x = s;
        p = ACC_W'(c * x);
        return p <<< scw;
    endfunction : side_term

    // Center tap product at the fixed finest weight
    function automatic pefcfg_acc_t center_term(
        input logic [CREG_W-1:0] r,
        input logic [SAMPLE_W-1:0] s
    );
        logic signed [CENTER_W-1:0] c;
        logic signed [SAMPLE_W-1:0] x;
        c = r[CENTER_W-1:0];
        x = s;
        return ACC_W'(c * x);
    endfunction : center_term

    // Drop fraction bits and clip to sample range
    function automatic logic [SAMPLE_W-1:0] clip(input pefcfg_acc_t v);
        pefcfg_acc_t t;
        pefcfg_acc_t hi;
        pefcfg_acc_t lo;
        t = v >>> WEIGHT_FRAC;
        hi = ACC_W'((1 << (SAMPLE_W - 1)) - 1);
        lo = -hi - ACC_W'(1);
        if (t > hi) begin
            return hi[SAMPLE_W-1:0];
        end else if (t < lo) begin
            return lo[SAMPLE_W-1:0];
        end
        return t[SAMPLE_W-1:0];
    endfunction : clip

    // Byte-lane merge of a bus write into an old word
    function automatic logic [31:0] lane_merge(
        input logic [31:0] old,
        input logic [31:0] wdat,
        input logic [3:0] sel
    );
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = wdat[i*8 +: 8];
            end
        end
        return r;
    endfunction : lane_merge

    // Registers
    logic [CFG_W-1:0] cfg_q;
    logic [TAP_W-1:0] tap0_q;
    logic [TAP_W-1:0] tap1_q;
    logic [CREG_W-1:0] center_q;
    logic [TAP_W-1:0] b_tap0_q;
    logic [TAP_W-1:0] b_tap1_q;
    logic [CREG_W-1:0] b_center_q;
    logic link_en_q;
    logic late_wr_q;
    logic ack_q;
    logic [31:0] dat_q;

    // Bus decode
    logic [IDX_W-1:0] idx;
    logic req;
    logic wr_en;
    logic [31:0] old_word;
    logic [31:0] new_word;
    logic [31:0] rd_word;
    logic filt_reg_hit;

    // Decoded configuration
    logic [1:0] filter_mode;
    logic [2:0] side_weight;
    logic merge_filters;
    logic share_coefficients;
    logic filter_on;

    // Sample history, index 0 is the previous beat
    logic [SAMPLE_W-1:0] hist_a_q [4];
    logic [SAMPLE_W-1:0] hist_b_q [4];

    // Datapath
    logic [TAP_W-1:0] bc0;
    logic [TAP_W-1:0] bc1;
    logic [CREG_W-1:0] bcc;
    logic [SAMPLE_W-1:0] a_x1;
    logic [SAMPLE_W-1:0] a_x4;
    logic [SAMPLE_W-1:0] b_x1;
    logic [SAMPLE_W-1:0] b_x4;
    pefcfg_acc_t acc_a;
    pefcfg_acc_t acc_b;
    logic [SAMPLE_W-1:0] res_a;
    logic [SAMPLE_W-1:0] res_b;
    logic take;
    logic buf_ready;
    logic [2*SAMPLE_W-1:0] buf_out;

    // Word index of the byte address
    assign idx = IDX_W'(adr_i[ADR_W-1:2]);
    assign req = cyc_i && stb_i && !ack_q;
    assign wr_en = req && we_i;

    // Configuration fields
    assign filter_mode = cfg_q[CFG_MODE_LSB +: 2];
    assign merge_filters = cfg_q[CFG_MERGE_BIT];
    assign share_coefficients = cfg_q[CFG_SHARE_BIT];
    assign filter_on = (filter_mode == MODE_ON);

    // Side weight above the legal range is held at the top
    always_comb begin
        side_weight = cfg_q[CFG_SCW_LSB +: 3];
        if (side_weight > SCW_MAX) begin
            side_weight = SCW_MAX;
        end
    end

    // Current word of the addressed register
    always_comb begin
        old_word = '0;
        unique case (idx)
            IDX_CFG: old_word = 32'(cfg_q);
            IDX_TAP0: old_word = 32'(tap0_q);
            IDX_TAP1: old_word = 32'(tap1_q);
            IDX_CENTER: old_word = 32'(center_q);
            IDX_B_TAP0: old_word = 32'(b_tap0_q);
            IDX_B_TAP1: old_word = 32'(b_tap1_q);
            IDX_B_CENTER: old_word = 32'(b_center_q);
            IDX_LINK: old_word = 32'(link_en_q);
            IDX_STATUS: begin
                old_word[STAT_ACTIVE_BIT] = filter_on;
                old_word[STAT_RSVD_BIT] = filter_mode[0];
                old_word[STAT_LATE_BIT] = late_wr_q;
            end
            default: old_word = '0;
        endcase
        new_word = lane_merge(old_word, dat_i, sel_i);
        rd_word = old_word;
    end

    // Filter registers whose change needs the link stopped
    assign filt_reg_hit = (idx == IDX_CFG) || (idx == IDX_TAP0) ||
        (idx == IDX_TAP1) || (idx == IDX_CENTER) ||
        (idx == IDX_B_TAP0) || (idx == IDX_B_TAP1) ||
        (idx == IDX_B_CENTER);

    // Bus answer one cycle after the request, dropped the next
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            dat_q <= '0;
        end else begin
            ack_q <= cyc_i && stb_i && !ack_q;
            if (req && !we_i) begin
                dat_q <= rd_word;
            end
        end
    end

    // Configuration register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg_q <= CFG_RST;
        end else if (wr_en && idx == IDX_CFG) begin
            cfg_q <= new_word[CFG_W-1:0];
        end
    end

    // Channel a coefficient registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tap0_q <= TAP_RST;
            tap1_q <= TAP_RST;
            center_q <= CREG_RST;
        end else if (wr_en) begin
            if (idx == IDX_TAP0) begin
                tap0_q <= new_word[TAP_W-1:0];
            end
            if (idx == IDX_TAP1) begin
                tap1_q <= new_word[TAP_W-1:0];
            end
            if (idx == IDX_CENTER) begin
                center_q <= new_word[CREG_W-1:0];
            end
        end
    end

    // Channel b coefficient registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            b_tap0_q <= TAP_RST;
            b_tap1_q <= TAP_RST;
            b_center_q <= CREG_RST;
        end else if (wr_en) begin
            if (idx == IDX_B_TAP0) begin
                b_tap0_q <= new_word[TAP_W-1:0];
            end
            if (idx == IDX_B_TAP1) begin
                b_tap1_q <= new_word[TAP_W-1:0];
            end
            if (idx == IDX_B_CENTER) begin
                b_center_q <= new_word[CREG_W-1:0];
            end
        end
    end

    // Link enable control bit
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            link_en_q <= LINK_RST;
        end else if (wr_en && idx == IDX_LINK && sel_i[0]) begin
            link_en_q <= dat_i[0];
        end
    end

    // Sticky flag for filter writes with the link running
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            late_wr_q <= 1'b0;
        end else if (wr_en && filt_reg_hit && link_en_q) begin
            late_wr_q <= 1'b1;
        end else if (wr_en && idx == IDX_STATUS && sel_i[0] &&
                     dat_i[STAT_LATE_BIT]) begin
            late_wr_q <= 1'b0;
        end
    end

    // Coefficients for channel b
    always_comb begin
        if (share_coefficients || merge_filters) begin
            bc0 = tap0_q;
            bc1 = tap1_q;
            bcc = center_q;
        end else begin
            bc0 = b_tap0_q;
            bc1 = b_tap1_q;
            bcc = b_center_q;
        end
    end

    // Delayed operands, interleaved order when merged
    always_comb begin
        if (merge_filters) begin
            a_x1 = hist_b_q[0];
            a_x4 = hist_a_q[1];
            b_x1 = in_a_i;
            b_x4 = hist_b_q[1];
        end else begin
            a_x1 = hist_a_q[0];
            a_x4 = hist_a_q[3];
            b_x1 = hist_b_q[0];
            b_x4 = hist_b_q[3];
        end
    end

    // Tap sums; the center tap sits four samples back
    always_comb begin
        acc_a = side_term(tap0_q, in_a_i, side_weight) +
            side_term(tap1_q, a_x1, side_weight) +
            center_term(center_q, a_x4);
        acc_b = side_term(bc0, in_b_i, side_weight) +
            side_term(bc1, b_x1, side_weight) +
            center_term(bcc, b_x4);
    end

    // Output choice: filtered or passed through
    always_comb begin
        if (filter_on) begin
            res_a = clip(acc_a);
            res_b = clip(acc_b);
        end else begin
            res_a = in_a_i;
            res_b = in_b_i;
        end
    end

    // Accepted beat shifts the history
    assign take = in_valid_i && buf_ready;
    assign in_ready_o = buf_ready;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < 4; i++) begin
                hist_a_q[i] <= '0;
                hist_b_q[i] <= '0;
            end
        end else if (take) begin
            hist_a_q[0] <= in_a_i;
            hist_b_q[0] <= in_b_i;
            for (int i = 1; i < 4; i++) begin
                hist_a_q[i] <= hist_a_q[i-1];
                hist_b_q[i] <= hist_b_q[i-1];
            end
        end
    end

    // Result buffer toward the consumer
    pefcfg_buf #(
        .W(2 * SAMPLE_W),
        .DEPTH(BUF_DEPTH)
    ) u_buf (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .in_valid_i(in_valid_i),
        .in_ready_o(buf_ready),
        .in_data_i({res_b, res_a}),
        .out_valid_o(out_valid_o),
        .out_ready_i(out_ready_i),
        .out_data_o(buf_out)
    );

    // Outputs
    assign out_a_o = buf_out[SAMPLE_W-1:0];
    assign out_b_o = buf_out[2*SAMPLE_W-1:SAMPLE_W];
    assign ack_o = ack_q;
    assign dat_o = dat_q;
    assign serial_link_enable_o = link_en_q;
endmodule : pefcfg_top
`default_nettype wire

/* File: sim/pefcfg_monitor.sv */
// Purpose: Port checker for the filter configuration block
// Assumes: Registers are written with all byte lanes on
// Notes: Shadows cfg and tap0 from bus writes
`default_nettype none
module pefcfg_monitor
    import pefcfg_pkg::*;
#(
    parameter int ADR_W = 16
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [ADR_W-1:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    input wire logic in_valid_i,
    input wire logic in_ready_o,
    input wire logic [SAMPLE_W-1:0] in_a_i,
    input wire logic [SAMPLE_W-1:0] in_b_i,
    input wire logic out_valid_o,
    input wire logic out_ready_i,
    input wire logic [SAMPLE_W-1:0] out_a_o,
    input wire logic [SAMPLE_W-1:0] out_b_o,
    input wire logic serial_link_enable_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic [CFG_W-1:0] cfg_q;
    logic [TAP_W-1:0] tap0_q;
    logic [IDX_W-1:0] idx;
    logic acc;
    assign idx = IDX_W'(adr_i[ADR_W-1:2]);
    assign acc = cyc_i && stb_i && ack_o;
    // Shadow of what software wrote
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg_q <= CFG_RST;
            tap0_q <= TAP_RST;
        end else if (acc && we_i && idx == IDX_CFG) begin
            cfg_q <= dat_i[CFG_W-1:0];
        end else if (acc && we_i && idx == IDX_TAP0) begin
            tap0_q <= dat_i[TAP_W-1:0];
        end
    end
    a_ack_next: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("ack late");
    a_ack_pulse: assert property (ack_o |=> !ack_o)
        else $error("ack stuck");
    a_cfg_read: assert property (acc && !we_i && idx == IDX_CFG
        |-> dat_o[CFG_W-1:0] == cfg_q) else $error("cfg readback");
    a_tap0_read: assert property (acc && !we_i && idx == IDX_TAP0
        |-> dat_o[TAP_W-1:0] == tap0_q) else $error("tap0 readback");
    a_pass_thru: assert property (in_valid_i && in_ready_o
        && !out_valid_o && cfg_q[1:0] != MODE_ON |=> out_valid_o
        && out_a_o == $past(in_a_i) && out_b_o == $past(in_b_i))
        else $error("pass-through");
    a_out_hold: assert property (out_valid_o && !out_ready_i |=>
        out_valid_o && $stable(out_a_o) && $stable(out_b_o))
        else $error("output dropped");
    a_ready_empty: assert property (!out_valid_o |-> in_ready_o)
        else $error("ready low while empty");
    a_reset_off: assert property ($fell(rst_i) |->
        !serial_link_enable_o && !out_valid_o && !ack_o)
        else $error("reset state");
endmodule : pefcfg_monitor
`default_nettype wire

/* File: sim/pefcfg_sink.sv */
// Purpose: Output framing model that takes result pairs
// Assumes: stall_i asks it to hold ready low
// Notes: Accepted pairs wait in queues for the bench
`default_nettype none
module pefcfg_sink
    import pefcfg_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic stall_i,
    input wire logic valid_i,
    input wire logic [SAMPLE_W-1:0] a_i,
    input wire logic [SAMPLE_W-1:0] b_i,
    output logic ready_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [SAMPLE_W-1:0] qa[$];
    logic [SAMPLE_W-1:0] qb[$];
    initial ready_o = 1'b0;
    // Ready follows stall one edge late
    always @(posedge clk_i) begin
        ready_o <= !rst_i && !stall_i;
        if (!rst_i && valid_i && ready_o) begin
            qa.push_back(a_i);
            qb.push_back(b_i);
        end
    end
endmodule : pefcfg_sink
`default_nettype wire

/* File: sim/tb.sv */
// Purpose: Self-checking bench for the filter configuration block
// Assumes: Coefficients of channel b keep their reset value
// Notes: Results are taken by the sink model
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import pefcfg_pkg::*;
    logic clk, rst, cyc, stb, we, ack, iv, ir, ov, ord, lnk, stall;
    logic [15:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat, rdat;
    logic [11:0] ia, ib, oa, ob;
    int n_mismatch = 0;
    int checks = 0;
    pefcfg_top u_dut (.clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb),
        .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat),
        .ack_o(ack), .in_valid_i(iv), .in_ready_o(ir), .in_a_i(ia),
        .in_b_i(ib), .out_valid_o(ov), .out_ready_i(ord), .out_a_o(oa),
        .out_b_o(ob), .serial_link_enable_o(lnk));
    pefcfg_sink u_sink (.clk_i(clk), .rst_i(rst), .stall_i(stall),
        .valid_i(ov), .a_i(oa), .b_i(ob), .ready_o(ord));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic end_sim;
        if (n_mismatch == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : end_sim
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // One classic bus cycle, released after the ack edge
    task automatic wb(input logic w, input logic [13:0] i,
                      input logic [31:0] d, output logic [31:0] q);
        int t;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {i, 2'b00};
        wdat <= d;
        t = 0;
        do begin
            @(posedge clk);
            t++;
        end while (ack !== 1'b1 && t < 50);
        if (ack !== 1'b1) begin
            n_mismatch++;
            $display("MISMATCH %0t bus cycle not acknowledged", $time);
        end
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb
    task automatic wr(input logic [13:0] i, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, i, d, q);
    endtask : wr
    task automatic rd(input logic [13:0] i, input logic [31:0] e);
        logic [31:0] q;
        wb(1'b0, i, 32'h0, q);
        chk(q, e);
    endtask : rd
    // Offer one sample pair until taken
    task automatic push(input logic [11:0] a, input logic [11:0] b);
        int t;
        @(posedge clk);
        iv <= 1'b1;
        ia <= a;
        ib <= b;
        t = 0;
        do begin
            @(posedge clk);
            t++;
        end while (ir !== 1'b1 && t < 50);
        if (ir !== 1'b1) begin
            n_mismatch++;
            $display("MISMATCH %0t sample pair not taken", $time);
        end
        iv <= 1'b0;
    endtask : push
    task automatic pull(input logic [11:0] ea, input logic [11:0] eb);
        int t;
        t = 0;
        while (u_sink.qa.size() == 0 && t < 50) begin
            @(posedge clk);
            t++;
        end
        if (u_sink.qa.size() == 0) begin
            n_mismatch++;
            $display("MISMATCH %0t no result pair arrived", $time);
        end else begin
            chk(u_sink.qa.pop_front(), ea);
            chk(u_sink.qb.pop_front(), eb);
        end
    endtask : pull
    // Discard results, waiting for each one to arrive
    task automatic drop(input int n);
        int t;
        repeat (n) begin
            t = 0;
            while (u_sink.qa.size() == 0 && t < 50) begin
                @(posedge clk);
                t++;
            end
            if (u_sink.qa.size() == 0) begin
                n_mismatch++;
                $display("MISMATCH %0t result pair missing", $time);
            end else begin
                void'(u_sink.qa.pop_front());
                void'(u_sink.qb.pop_front());
            end
        end
    endtask : drop
    task automatic t_regs;
        chk(lnk, 1'b0);
        rd(IDX_CFG, 32'h0);
        rd(IDX_TAP0, 32'h0);
        rd(IDX_TAP1, 32'h0);
        wr(IDX_TAP0, 32'h0000ABCD);
        wr(IDX_TAP1, 32'h00005432);
        wr(IDX_CFG, 32'h000000F8);
        wr(14'h0401, 32'hFFFFFFFF);
        rd(IDX_TAP0, 32'h0000ABCD);
        rd(IDX_TAP1, 32'h00005432);
        rd(IDX_CFG, 32'h000000F8);
        rd(14'h0401, 32'h0);
    endtask : t_regs
    // Disabled mode leaves samples untouched despite loaded taps
    task automatic t_pass;
        push(12'h800, 12'h7FF);
        push(12'h123, 12'hEDC);
        pull(12'h800, 12'h7FF);
        pull(12'h123, 12'hEDC);
    endtask : t_pass
    task automatic t_scw;
        int s, e, f;
        wr(IDX_TAP1, 32'h0);
        wr(IDX_TAP0, 32'h00000400);
        for (s = 0; s <= 6; s++) begin
            wr(IDX_CFG, 32'h42 | (s << 2));
            push(12'd1000, -12'sd1000);
            e = (1024000 <<< s) >>> 16;
            f = (-1024000 <<< s) >>> 16;
            pull(e[11:0], f[11:0]);
        end
        wr(IDX_TAP0, 32'h0000FC00);
        push(12'd1000, -12'sd1000);
        pull(-12'sd1000, 12'd1000);
    endtask : t_scw
    // Center tap ignores side weight and reaches four beats back
    task automatic t_center;
        int k;
        wr(IDX_TAP0, 32'h0);
        wr(IDX_CENTER, 32'h00010000);
        for (k = 1; k <= 6; k++) push(12'(k * 100), 12'(-k * 100));
        drop(4);
        pull(12'd100, -12'sd100);
        pull(12'd200, -12'sd200);
        wr(IDX_CENTER, 32'h0);
    endtask : t_center
    task automatic t_tap1;
        wr(IDX_CFG, 32'h0000001A);
        wr(IDX_TAP1, 32'h00000400);
        push(12'd300, 12'd5);
        push(12'd400, 12'd6);
        drop(1);
        pull(12'd300, 12'd0);
        wr(IDX_CFG, 32'h0000003A);
        push(12'd111, 12'd222);
        push(12'd333, 12'd444);
        drop(1);
        pull(12'd222, 12'd333);
    endtask : t_tap1
    // Stalled consumer fills the buffer, then drains in order
    task automatic t_buf;
        wr(IDX_CFG, 32'h0);
        stall <= 1'b1;
        push(12'h001, 12'h00A);
        push(12'h002, 12'h00B);
        @(posedge clk);
        chk(ir, 1'b0);
        fork
            push(12'h003, 12'h00C);
            begin
                repeat (6) @(posedge clk);
                stall <= 1'b0;
            end
        join
        pull(12'h001, 12'h00A);
        pull(12'h002, 12'h00B);
        pull(12'h003, 12'h00C);
    endtask : t_buf
    // Link enable, late-write flag, its clear and the active bit
    task automatic t_link;
        wr(IDX_LINK, 32'h00000001);
        chk(lnk, 1'b1);
        rd(IDX_STATUS, 32'h0);
        wr(IDX_TAP1, 32'h0);
        rd(IDX_STATUS, 32'h00000004);
        wr(IDX_LINK, 32'h0);
        chk(lnk, 1'b0);
        rd(IDX_LINK, 32'h0);
        wr(IDX_STATUS, 32'h00000004);
        rd(IDX_STATUS, 32'h0);
        wr(IDX_CFG, 32'h00000002);
        rd(IDX_STATUS, 32'h00000001);
        wr(IDX_CFG, 32'h0);
    endtask : t_link
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        end_sim;
    end
    initial begin
        rst = 1'b1;
        {cyc, stb, we, iv, stall} = '0;
        sel = 4'hF;
        adr = '0;
        wdat = '0;
        {ia, ib} = '0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        t_regs;
        t_pass;
        t_scw;
        t_center;
        t_tap1;
        t_buf;
        t_link;
        end_sim;
    end
endmodule : tb
bind pefcfg_top pefcfg_monitor #(.ADR_W(ADR_W)) u_mon (.clk_i(clk_i),
    .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
    .ack_o(ack_o), .in_valid_i(in_valid_i), .in_ready_o(in_ready_o),
    .in_a_i(in_a_i), .in_b_i(in_b_i), .out_valid_o(out_valid_o),
    .out_ready_i(out_ready_i), .out_a_o(out_a_o), .out_b_o(out_b_o),
    .serial_link_enable_o(serial_link_enable_o));
`default_nettype wire
